/* hdl/tpoc_top.sv */
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - One decimal point position serves both measurement and comparison values.
// - Displayed value is input pulse frequency times the prescale factor.
// - Prescale factor resets to 1,000, so the display reads thousandths of a hertz.
// - Set value above maximum minus prescale keeps the output off.
// - Frequency forced to zero after auto-zero time without pulses.
// - After power-up measurement and outputs stay off for startup time.
// - Peak and bottom tracked when enabled; both restart on any setting write except set values, bottom also on reset.
// - Peak value survives a supply interruption.
// - Hysteresis band in post-prescale units around the set value.
// - Output held on for the OFF delay after comparison drops.
// - Measurement continues while the output is frozen in the delay.
// - Set values above the upper limit are rejected in run mode.
// - ON-count alarm threshold 0 to 9999 thousands; zero disables it.
// - ON count above a nonzero threshold raises the alarm.
// - Two outputs keep separate counts and thresholds; either raises alarm.
// - Monitor values are read-only, count divided by 1,000.
// - Key restrictions only while protect switch on; indicator follows switch.
// - Seven protect levels, default one; display, hold, up gated per level.
// - Protected keys never enter DIP monitor or function setting modes.
module tpoc_top
  import tpoc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     SYS_RST,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]        AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  output logic      [31:0]              AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  // Sensor and keys
  input  wire logic                     PULSE_IN,
  input  wire logic                     KEY_PROTECT_SWITCH,
  input  wire logic                     KEY_MODE,
  input  wire logic                     KEY_DISPLAY,
  input  wire logic                     KEY_HOLD,
  input  wire logic                     KEY_UP,
  // Outputs
  output logic                          FIRST_OUTPUT,
  output logic                          SECOND_OUTPUT,
  output logic                          COUNT_ALARM,
  output logic                          PROTECT_INDICATOR,
  output logic                          MODE_KEY_EVENT,
  output logic                          DISPLAY_KEY_EVENT,
  output logic                          HOLD_KEY_EVENT,
  output logic                          UP_KEY_EVENT,
  output logic      [DP_W-1:0]          DECIMAL_POINT_POSITION,
  output logic      [VAL_W-1:0]         DISPLAY_VALUE
);
  import tpoc_pkg::*;

  if (TICK_CYCLES_P < 2) begin : g_tick_chk
    $error("TICK_CYCLES_P must be at least 2");
  end

  localparam int TICK_W = $clog2(TICK_CYCLES_P);
  localparam int NKEY   = 6;

  // Configuration
  logic             peak_bottom_hold_enable;
  logic [1:0]       lower_mode;
  logic [DP_W-1:0]  decimal_point_position;
  logic [VAL_W-1:0] prescale_factor;
  logic [MS_W-1:0]  auto_zero_time;
  logic [MS_W-1:0]  startup_inhibit_time;
  logic [VAL_W-1:0] hysteresis;
  logic [MS_W-1:0]  output_off_delay;
  logic [VAL_W-1:0] set_value_upper_limit;
  logic [VAL_W-1:0] set_value1;
  logic [VAL_W-1:0] set_value2;
  logic [LVL_W-1:0] key_protect_level;
  logic [MON_W-1:0] on_count_alarm_threshold1;
  logic [MON_W-1:0] on_count_alarm_threshold2;
  logic             sv_rejected;
  logic             config_changed;

  // Bus
  logic             wait_r;
  logic             bus_wr;
  logic             bus_rd;

  // Measurement
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [MS_W-1:0]   gate_ms;
  logic [MS_W-1:0]   idle_ms;
  logic [MS_W-1:0]   startup_ms;
  logic              started;
  logic              zeroed;
  logic [VAL_W-1:0]  pulse_cnt;
  logic [VAL_W-1:0]  frequency;
  logic [VAL_W-1:0]  measure;
  logic              measure_new;
  logic [VAL_W-1:0]  peak = '0;
  logic [VAL_W-1:0]  bottom;
  logic              track_valid;
  logic [2*VAL_W-1:0] product;

  // Pins through two flops before any use
  logic [NKEY-1:0]  pin_meta;
  logic [NKEY-1:0]  pin_sync;
  logic [NKEY-1:0]  pin_prev;
  logic             pulse_edge;
  logic             protect_on;
  logic             alarm_hidden;

  tpoc_chan_if chan1 ();
  tpoc_chan_if chan2 ();

  function automatic logic [VAL_W-1:0] clamp_val(input logic [31:0] d);
    clamp_val = (d > 32'(MAX_COUNTABLE)) ? MAX_COUNTABLE : d[VAL_W-1:0];
  endfunction

  function automatic logic key_allowed(input logic [1:0] key, input logic [LVL_W-1:0] lvl);
    // key: 0 display, 1 hold, 2 up
    unique case (key)
      2'd0:    key_allowed = lvl <= 3'd4;
      2'd1:    key_allowed = !(lvl == 3'd2 || lvl == 3'd4 || lvl == 3'd5 || lvl == 3'd7);
      2'd2:    key_allowed = !(lvl == 3'd3 || lvl == 3'd4 || lvl == 3'd5);
      default: key_allowed = 1'b0;
    endcase
  endfunction

  // Request taken on the edge where waitrequest is low
  assign bus_wr = AVS_WRITE && !wait_r;
  assign bus_rd = AVS_READ && !wait_r;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      wait_r <= 1'b1;
    else if ((AVS_READ || AVS_WRITE) && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end
  assign AVS_WAITREQUEST = wait_r;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      peak_bottom_hold_enable   <= 1'b0;
      lower_mode                <= 2'b00;
      decimal_point_position    <= DECIMAL_RST;
      prescale_factor           <= PRESCALE_RST;
      auto_zero_time            <= AUTO_ZERO_RST;
      startup_inhibit_time      <= STARTUP_RST;
      hysteresis                <= HYST_RST;
      output_off_delay          <= OFF_DELAY_RST;
      set_value_upper_limit     <= MAX_COUNTABLE;
      set_value1                <= MAX_COUNTABLE;
      set_value2                <= '0;
      key_protect_level         <= KEY_LEVEL_MIN;
      on_count_alarm_threshold1 <= '0;
      on_count_alarm_threshold2 <= '0;
      sv_rejected               <= 1'b0;
      config_changed            <= 1'b0;
    end else begin
      config_changed <= 1'b0;
      if (bus_wr) begin
        unique case (AVS_ADDRESS)
          REG_CTRL: begin
            peak_bottom_hold_enable <= AVS_WRITEDATA[CTRL_PEAK_EN_BIT];
            lower_mode <= {AVS_WRITEDATA[CTRL_LOW2_BIT], AVS_WRITEDATA[CTRL_LOW1_BIT]};
            config_changed <= 1'b1;
          end
          REG_DECIMAL: begin
            decimal_point_position <= AVS_WRITEDATA[DP_W-1:0];
            config_changed <= 1'b1;
          end
          REG_PRESCALE: begin
            prescale_factor <= clamp_val(AVS_WRITEDATA);
            config_changed <= 1'b1;
          end
          REG_AUTO_ZERO: begin
            auto_zero_time <= AVS_WRITEDATA[MS_W-1:0];
            config_changed <= 1'b1;
          end
          REG_STARTUP: begin
            startup_inhibit_time <= AVS_WRITEDATA[MS_W-1:0];
            config_changed <= 1'b1;
          end
          REG_HYST: begin
            hysteresis <= clamp_val(AVS_WRITEDATA);
            config_changed <= 1'b1;
          end
          REG_OFF_DELAY: begin
            output_off_delay <= AVS_WRITEDATA[MS_W-1:0];
            config_changed <= 1'b1;
          end
          REG_SV_LIMIT: begin
            set_value_upper_limit <= clamp_val(AVS_WRITEDATA);
            config_changed <= 1'b1;
          end
          REG_SET_VALUE1, REG_SET_VALUE2: begin
            if (AVS_WRITEDATA > 32'(set_value_upper_limit)) begin
              sv_rejected <= 1'b1;
            end else begin
              sv_rejected <= 1'b0;
              if (AVS_ADDRESS == REG_SET_VALUE1)
                set_value1 <= AVS_WRITEDATA[VAL_W-1:0];
              else
                set_value2 <= AVS_WRITEDATA[VAL_W-1:0];
            end
          end
          REG_KEY_LEVEL: begin
            if (AVS_WRITEDATA[LVL_W-1:0] >= KEY_LEVEL_MIN && AVS_WRITEDATA < 32'(KEY_LEVEL_MAX) + 1)
              key_protect_level <= AVS_WRITEDATA[LVL_W-1:0];
            config_changed <= 1'b1;
          end
          REG_ALARM_THR1: begin
            if (AVS_WRITEDATA <= 32'(ALARM_THR_MAX))
              on_count_alarm_threshold1 <= AVS_WRITEDATA[MON_W-1:0];
            config_changed <= 1'b1;
          end
          REG_ALARM_THR2: begin
            if (AVS_WRITEDATA <= 32'(ALARM_THR_MAX))
              on_count_alarm_threshold2 <= AVS_WRITEDATA[MON_W-1:0];
            config_changed <= 1'b1;
          end
          default: ; // Monitors, status and unmapped: writes ignored
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      AVS_READDATA <= '0;
    end else if ((AVS_READ || AVS_WRITE) && wait_r) begin
      AVS_READDATA <= '0;
      if (AVS_READ) begin
        unique case (AVS_ADDRESS)
          REG_CTRL:       AVS_READDATA <= 32'({lower_mode, peak_bottom_hold_enable});
          REG_DECIMAL:    AVS_READDATA <= 32'(decimal_point_position);
          REG_PRESCALE:   AVS_READDATA <= 32'(prescale_factor);
          REG_AUTO_ZERO:  AVS_READDATA <= 32'(auto_zero_time);
          REG_STARTUP:    AVS_READDATA <= 32'(startup_inhibit_time);
          REG_HYST:       AVS_READDATA <= 32'(hysteresis);
          REG_OFF_DELAY:  AVS_READDATA <= 32'(output_off_delay);
          REG_SV_LIMIT:   AVS_READDATA <= 32'(set_value_upper_limit);
          REG_SET_VALUE1: AVS_READDATA <= 32'(set_value1);
          REG_SET_VALUE2: AVS_READDATA <= 32'(set_value2);
          REG_KEY_LEVEL:  AVS_READDATA <= 32'(key_protect_level);
          REG_ALARM_THR1: AVS_READDATA <= 32'(on_count_alarm_threshold1);
          REG_ALARM_THR2: AVS_READDATA <= 32'(on_count_alarm_threshold2);
          REG_STATUS:     AVS_READDATA <= 32'({zeroed, protect_on, chan2.out, chan1.out,
                                               chan2.alarm, chan1.alarm, sv_rejected, started});
          REG_MEASURE:    AVS_READDATA <= 32'(measure);
          REG_PEAK:       AVS_READDATA <= 32'(peak);
          REG_BOTTOM:     AVS_READDATA <= 32'(bottom);
          REG_MONITOR1:   AVS_READDATA <= 32'(chan1.monitor);
          REG_MONITOR2:   AVS_READDATA <= 32'(chan2.monitor);
          default:        AVS_READDATA <= '0;
        endcase
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= {KEY_UP, KEY_HOLD, KEY_DISPLAY, KEY_MODE, KEY_PROTECT_SWITCH, PULSE_IN};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pulse_edge = pin_sync[0] && !pin_prev[0];
  assign protect_on = pin_sync[1];

  // Millisecond tick
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      startup_ms <= '0;
      started    <= 1'b0;
    end else if (!started) begin
      if (startup_ms >= startup_inhibit_time)
        started <= 1'b1;
      else if (tick)
        startup_ms <= startup_ms + 1'b1;
    end
  end

  // One-second gate counts pulses per second directly
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !started) begin
      gate_ms     <= '0;
      pulse_cnt   <= '0;
      frequency   <= '0;
      idle_ms     <= '0;
      zeroed      <= 1'b0;
      measure_new <= 1'b0;
    end else begin
      measure_new <= 1'b0;
      if (pulse_edge) begin
        idle_ms <= '0;
        zeroed  <= 1'b0;
      end else if (tick && idle_ms != '1) begin
        idle_ms <= idle_ms + 1'b1;
      end
      if (tick && gate_ms == MS_W'(GATE_MS - 1)) begin
        gate_ms     <= '0;
        pulse_cnt   <= '0;
        frequency   <= zeroed ? '0 : pulse_cnt;
        measure_new <= 1'b1;
      end else begin
        if (tick)
          gate_ms <= gate_ms + 1'b1;
        if (pulse_edge && pulse_cnt != MAX_COUNTABLE)
          pulse_cnt <= pulse_cnt + 1'b1;
      end
      if (!pulse_edge && auto_zero_time != '0 && idle_ms >= auto_zero_time) begin
        zeroed    <= 1'b1;
        frequency <= '0;
      end
    end
  end

  assign product = frequency * prescale_factor;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST)
      measure <= '0;
    else
      measure <= (product > (2*VAL_W)'(MAX_COUNTABLE)) ? MAX_COUNTABLE
                                                         : product[VAL_W-1:0];
  end

  // Peak has no reset: it models retained storage
  always_ff @(posedge CLK_SYS) begin
    if (config_changed)
      peak <= '0;
    else if (peak_bottom_hold_enable && measure_new && measure > peak)
      peak <= measure;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || config_changed) begin
      bottom      <= MAX_COUNTABLE;
      track_valid <= 1'b0;
    end else if (peak_bottom_hold_enable && measure_new) begin
      track_valid <= 1'b1;
      if (!track_valid || measure < bottom)
        bottom <= measure;
    end
  end

  // Channel feeds; one hysteresis and delay shared by both outputs
  assign chan1.enable     = started;
  assign chan1.tick       = tick;
  assign chan1.lower_mode = lower_mode[0];
  assign chan1.value      = measure;
  assign chan1.set_value  = set_value1;
  assign chan1.hyst       = hysteresis;
  assign chan1.prescale   = prescale_factor;
  assign chan1.off_delay  = output_off_delay;
  assign chan1.alarm_thr  = on_count_alarm_threshold1;
  assign chan2.enable     = started;
  assign chan2.tick       = tick;
  assign chan2.lower_mode = lower_mode[1];
  assign chan2.value      = measure;
  assign chan2.set_value  = set_value2;
  assign chan2.hyst       = hysteresis;
  assign chan2.prescale   = prescale_factor;
  assign chan2.off_delay  = output_off_delay;
  assign chan2.alarm_thr  = on_count_alarm_threshold2;

  tpoc_out_chan u_chan1 (.clk(CLK_SYS), .rst(SYS_RST), .ch(chan1));
  tpoc_out_chan u_chan2 (.clk(CLK_SYS), .rst(SYS_RST), .ch(chan2));

  assign FIRST_OUTPUT  = chan1.out;
  assign SECOND_OUTPUT = chan2.out;

  // Keys and indications
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      MODE_KEY_EVENT    <= 1'b0;
      DISPLAY_KEY_EVENT <= 1'b0;
      HOLD_KEY_EVENT    <= 1'b0;
      UP_KEY_EVENT      <= 1'b0;
      PROTECT_INDICATOR <= 1'b0;
    end else begin
      PROTECT_INDICATOR <= protect_on;
      MODE_KEY_EVENT    <= pin_sync[2] && !pin_prev[2] && !protect_on;
      DISPLAY_KEY_EVENT <= pin_sync[3] && !pin_prev[3] &&
                           (!protect_on || key_allowed(2'd0, key_protect_level));
      HOLD_KEY_EVENT    <= pin_sync[4] && !pin_prev[4] &&
                           (!protect_on || key_allowed(2'd1, key_protect_level));
      UP_KEY_EVENT      <= pin_sync[5] && !pin_prev[5] &&
                           (!protect_on || key_allowed(2'd2, key_protect_level));
    end
  end

  // Hold key hides the alarm; counting itself goes on
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      alarm_hidden <= 1'b0;
      COUNT_ALARM  <= 1'b0;
    end else begin
      if (HOLD_KEY_EVENT)
        alarm_hidden <= 1'b1;
      else if (!chan1.alarm && !chan2.alarm)
        alarm_hidden <= 1'b0;
      COUNT_ALARM <= (chan1.alarm || chan2.alarm) && !alarm_hidden;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      DECIMAL_POINT_POSITION <= DECIMAL_RST;
      DISPLAY_VALUE          <= '0;
    end else begin
      DECIMAL_POINT_POSITION <= decimal_point_position;
      DISPLAY_VALUE          <= measure;
    end
  end
endmodule

/* hdl/tpoc_pkg.sv */
package tpoc_pkg;
  localparam int VAL_W        = 20;
  localparam int CNT_W        = 24;
  localparam int MON_W        = 14;
  localparam int MS_W         = 16;
  localparam int LVL_W        = 3;
  localparam int DP_W         = 3;
  localparam int ADDR_W       = 8;

  localparam logic [VAL_W-1:0] MAX_COUNTABLE   = 20'hF423F;
  localparam logic [CNT_W-1:0] COUNT_SAT       = 24'hFFFFFF;
  localparam logic [MON_W-1:0] ALARM_THR_MAX   = 14'h270F;
  localparam int               ONS_PER_UNIT    = 1000;

  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_MS       = 1000;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL        = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DECIMAL     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PRESCALE    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_AUTO_ZERO   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STARTUP     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_HYST        = 8'h14;
  localparam logic [ADDR_W-1:0] REG_OFF_DELAY   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SV_LIMIT    = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_SET_VALUE1  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_SET_VALUE2  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_KEY_LEVEL   = 8'h28;
  localparam logic [ADDR_W-1:0] REG_ALARM_THR1  = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_ALARM_THR2  = 8'h30;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 8'h34;
  localparam logic [ADDR_W-1:0] REG_MEASURE     = 8'h38;
  localparam logic [ADDR_W-1:0] REG_PEAK        = 8'h3C;
  localparam logic [ADDR_W-1:0] REG_BOTTOM      = 8'h40;
  localparam logic [ADDR_W-1:0] REG_MONITOR1    = 8'h44;
  localparam logic [ADDR_W-1:0] REG_MONITOR2    = 8'h48;

  // CTRL fields
  localparam int CTRL_PEAK_EN_BIT = 0;
  localparam int CTRL_LOW1_BIT    = 1;
  localparam int CTRL_LOW2_BIT    = 2;

  // STATUS fields
  localparam int ST_STARTED_BIT   = 0;
  localparam int ST_REJECT_BIT    = 1;
  localparam int ST_ALARM1_BIT    = 2;
  localparam int ST_ALARM2_BIT    = 3;
  localparam int ST_FIRST_OUTPUT_BIT      = 4;
  localparam int ST_SECOND_OUTPUT_BIT      = 5;
  localparam int ST_PROTECT_BIT   = 6;
  localparam int ST_ZERO_BIT      = 7;

  // Reset values
  localparam logic [VAL_W-1:0] PRESCALE_RST   = 20'h003E8;
  localparam logic [MS_W-1:0]  AUTO_ZERO_RST  = 16'h03E8;
  localparam logic [MS_W-1:0]  STARTUP_RST    = 16'h0000;
  localparam logic [VAL_W-1:0] HYST_RST       = 20'h00001;
  localparam logic [MS_W-1:0]  OFF_DELAY_RST  = 16'h0000;
  localparam logic [DP_W-1:0]  DECIMAL_RST    = 3'h0;
  localparam logic [LVL_W-1:0] KEY_LEVEL_MIN  = 3'h1;
  localparam logic [LVL_W-1:0] KEY_LEVEL_MAX  = 3'h7;
endpackage

/* hdl/tpoc_chan_if.sv */
`timescale 1ns/1ps
interface tpoc_chan_if;
  import tpoc_pkg::*;
  logic             enable;
  logic             tick;
  logic             lower_mode;
  logic [VAL_W-1:0] value;
  logic [VAL_W-1:0] set_value;
  logic [VAL_W-1:0] hyst;
  logic [VAL_W-1:0] prescale;
  logic [MS_W-1:0]  off_delay;
  logic [MON_W-1:0] alarm_thr;
  logic             out;
  logic             alarm;
  logic [MON_W-1:0] monitor;

  modport ctrl (output enable, tick, lower_mode, value, set_value, hyst, prescale,
                off_delay, alarm_thr, input out, alarm, monitor);
  modport chan (input enable, tick, lower_mode, value, set_value, hyst, prescale,
                off_delay, alarm_thr, output out, alarm, monitor);
endinterface

/* hdl/tpoc_out_chan.sv */
`timescale 1ns/1ps
module tpoc_out_chan
  import tpoc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Channel link
  tpoc_chan_if.chan ch
);
  logic             cmp;
  logic             out_prev;
  logic [MS_W-1:0]  delay_ms;
  logic [CNT_W-1:0] on_count;
  logic             blocked;
  logic [VAL_W:0]   lim_wide;

  // Set value beyond the top of the range can never be reached
  assign lim_wide = {1'b0, MAX_COUNTABLE} - {1'b0, ch.prescale};
  assign blocked  = ch.prescale > MAX_COUNTABLE || {1'b0, ch.set_value} > lim_wide;

  always_ff @(posedge clk) begin
    if (rst || !ch.enable || blocked) begin
      cmp <= 1'b0;
    end else if (!ch.lower_mode) begin
      if (ch.value >= ch.set_value)
        cmp <= 1'b1;
      else if ({1'b0, ch.value} + {1'b0, ch.hyst} < {1'b0, ch.set_value})
        cmp <= 1'b0;
    end else begin
      if (ch.value < ch.set_value)
        cmp <= 1'b1;
      else if ({1'b0, ch.value} >= {1'b0, ch.set_value} + {1'b0, ch.hyst})
        cmp <= 1'b0;
    end
  end

  // Output stays frozen during the delay while measurement carries on
  always_ff @(posedge clk) begin
    if (rst || !ch.enable) begin
      ch.out   <= 1'b0;
      delay_ms <= '0;
    end else if (cmp) begin
      ch.out   <= 1'b1;
      delay_ms <= '0;
    end else if (ch.out) begin
      if (delay_ms >= ch.off_delay)
        ch.out <= 1'b0;
      else if (ch.tick)
        delay_ms <= delay_ms + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_prev <= 1'b0;
      on_count <= '0;
    end else begin
      out_prev <= ch.out;
      if (ch.out && !out_prev && on_count != COUNT_SAT)
        on_count <= on_count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch.alarm   <= 1'b0;
      ch.monitor <= '0;
    end else begin
      ch.alarm   <= ch.alarm_thr != '0 &&
                    on_count > CNT_W'(ch.alarm_thr) * CNT_W'(ONS_PER_UNIT);
      ch.monitor <= MON_W'(on_count / CNT_W'(ONS_PER_UNIT));
    end
  end
endmodule

/* dv/tpoc_sensor.sv */
`timescale 1ns/1ps
module tpoc_sensor (
  // Pulse source
  input  wire logic        clk,
  input  wire logic [15:0] period,
  output logic             pulse
);
  logic [15:0] cnt = 16'h0000;
  // Zero period parks the line low, as a stopped shaft does
  always_ff @(posedge clk) begin
    cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
    pulse <= (period != 16'h0000) && (cnt < (period >> 1));
  end
endmodule

/* dv/tpoc_top_monitor.sv */
`timescale 1ns/1ps
module tpoc_top_monitor
  import tpoc_pkg::*;
#(parameter int TICK_CYCLES_P = 10)(
  // Clock and bus
  input wire logic                         CLK_SYS, SYS_RST, AVS_READ, AVS_WRITE,
  input wire logic [tpoc_pkg::ADDR_W-1:0]  AVS_ADDRESS,
  input wire logic                         AVS_WAITREQUEST,
  // Keys and front panel
  input wire logic                         KEY_PROTECT_SWITCH, KEY_MODE, KEY_DISPLAY, KEY_UP,
  input wire logic                         PROTECT_INDICATOR, MODE_KEY_EVENT,
  input wire logic                         DISPLAY_KEY_EVENT, UP_KEY_EVENT,
  input wire logic [tpoc_pkg::DP_W-1:0]    DECIMAL_POINT_POSITION
);
  wire sw = KEY_PROTECT_SWITCH;
  wire wdec = AVS_WRITE && AVS_ADDRESS == REG_DECIMAL;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_ind_on; sw [*4] |-> PROTECT_INDICATOR; endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator dark");
  property p_ind_off; !sw [*4] |-> !PROTECT_INDICATOR; endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator lit");
  property p_mode_blk; sw [*4] |-> !MODE_KEY_EVENT; endproperty
  a_mode_blk: assert property (p_mode_blk) else $error("mode key passed");
  property p_up_free; !sw [*5] ##0 $rose(KEY_UP) |-> ##[2:3] UP_KEY_EVENT; endproperty
  a_up_free: assert property (p_up_free) else $error("up key lost");
  property p_up_cause; UP_KEY_EVENT |-> $past(KEY_UP, 3); endproperty
  a_up_cause: assert property (p_up_cause) else $error("up event unprompted");
  property p_disp_cause; DISPLAY_KEY_EVENT |-> $past(KEY_DISPLAY, 3); endproperty
  a_disp_cause: assert property (p_disp_cause) else $error("display event unprompted");
  property p_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_dp; !$stable(DECIMAL_POINT_POSITION) |-> $past(wdec) || $past(wdec, 2); endproperty
  a_dp: assert property (p_dp) else $error("decimal point moved alone");
  cover property (sw [*4] ##1 $rose(KEY_UP));
  cover property (UP_KEY_EVENT);
  cover property (!$stable(DECIMAL_POINT_POSITION));
endmodule
bind tpoc_top tpoc_top_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_mon (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .KEY_PROTECT_SWITCH(KEY_PROTECT_SWITCH),
  .KEY_MODE(KEY_MODE), .KEY_DISPLAY(KEY_DISPLAY), .KEY_UP(KEY_UP),
  .PROTECT_INDICATOR(PROTECT_INDICATOR), .MODE_KEY_EVENT(MODE_KEY_EVENT),
  .DISPLAY_KEY_EVENT(DISPLAY_KEY_EVENT), .UP_KEY_EVENT(UP_KEY_EVENT),
  .DECIMAL_POINT_POSITION(DECIMAL_POINT_POSITION));

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import tpoc_pkg::*;
  localparam logic [3:0] KT [1:7] = '{4'h7, 4'h5, 4'h6, 4'h4, 4'h0, 4'h3, 4'h1};
  logic              clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sw = 1'b0, wq, pin, o1, ind;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [31:0]       wd = 32'h0, q, rdat;
  logic [3:0]        keys = 4'h0, evs;
  logic [15:0]       per = 16'h0000;
  logic [DP_W-1:0]   dp;
  logic [VAL_W-1:0]  dv;
  logic              o2, ca;
  int                ev [4], n_fail = 0, cmp_count = 0;
  always #50 clk = ~clk;
  always @(posedge clk) for (int i = 0; i < 4; i++) ev[i] += int'(evs[i] === 1'b1);
  tpoc_sensor PS (.clk(clk), .period(per), .pulse(pin));
  tpoc_top #(.TICK_CYCLES_P(10)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(q), .AVS_WAITREQUEST(wq),
    .PULSE_IN(pin), .KEY_PROTECT_SWITCH(sw), .KEY_MODE(keys[3]), .KEY_DISPLAY(keys[2]),
    .KEY_HOLD(keys[1]), .KEY_UP(keys[0]), .FIRST_OUTPUT(o1), .SECOND_OUTPUT(o2), .COUNT_ALARM(ca),
    .PROTECT_INDICATOR(ind), .MODE_KEY_EVENT(evs[3]), .DISPLAY_KEY_EVENT(evs[2]),
    .HOLD_KEY_EVENT(evs[1]), .UP_KEY_EVENT(evs[0]), .DECIMAL_POINT_POSITION(dp),
    .DISPLAY_VALUE(dv));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] lo, hi, got);
    cmp_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    forever begin
      @(posedge clk);
      if (wq === 1'b0) break;
    end
    rdat = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] lo, hi, input string nm);
    acc(1'b0, a, 32'h0);
    chk(nm, lo, hi, rdat);
  endtask
  task automatic kp(input logic [3:0] e);
    foreach (ev[i]) ev[i] = 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      keys[i] <= 1'b1;
      repeat (4) @(posedge clk);
      keys[i] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    chk("keys", e, e, {ev[3] == 1, ev[2] == 1, ev[1] == 1, ev[0] == 1});
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(REG_PRESCALE, 1000, 1000, "prescale");
    rdc(REG_KEY_LEVEL, 1, 1, "key level");
    acc(1'b1, REG_MONITOR1, 32'h5);
    rdc(REG_MONITOR1, 0, 0, "monitor");
    acc(1'b1, REG_ALARM_THR1, 32'h270F);
    acc(1'b1, REG_ALARM_THR1, 32'h2710);
    rdc(REG_ALARM_THR1, 9999, 9999, "alarm thr");
    acc(1'b1, REG_DECIMAL, 32'h3);
    repeat (3) @(posedge clk);
    chk("dp", 3, 3, dp);
    acc(1'b1, REG_PRESCALE, 32'hC);
    acc(1'b1, REG_SET_VALUE1, 32'h3E8);
    per <= 16'h0064;
    repeat (22000) @(posedge clk);
    rdc(REG_MEASURE, 1188, 1212, "measure");
    chk("first_output", 1, 1, o1);
    chk("disp", 1188, 1212, dv);
    chk("second_output", 1, 1, o2);
    chk("alarm", 0, 0, ca);
    acc(1'b1, REG_AUTO_ZERO, 32'h5);
    per <= 16'h0000;
    repeat (200) @(posedge clk);
    rdc(REG_STATUS, 0, 32'hFFFF, "status");
    chk("zeroed", 1, 1, rdat[ST_ZERO_BIT]);
    acc(1'b1, REG_SV_LIMIT, 32'h64);
    acc(1'b1, REG_SET_VALUE1, 32'h65);
    rdc(REG_SET_VALUE1, 1000, 1000, "set value");
    sw <= 1'b1;
    for (int l = 1; l <= 7; l++) begin
      acc(1'b1, REG_KEY_LEVEL, l);
      kp(KT[l]);
    end
    sw <= 1'b0;
    kp(4'hF);
    stop_test();
  end
endmodule
